// file: rtc_fc_pkg.sv
// rtc_fc_pkg: constants and types for the rtc function-control block.
// assumes a 32.768 kHz oscillator level sampled on a fast system clock.
package rtc_fc_pkg;
  localparam logic [7:0] FUNC_CTRL_ADDR = 8'h28;
  localparam logic [7:0] FUNC_CTRL_RESET = 8'h00;
  localparam int HUND_EN_BIT = 7;
  localparam int PI_LSB = 5;
  localparam int MODE_BIT = 4;
  localparam int HALT_SRC_BIT = 3;
  localparam int COF_LSB = 0;
  localparam logic [1:0] PI_NONE = 2'h0;
  localparam logic [1:0] PI_SEC = 2'h1;
  localparam logic [1:0] PI_MIN = 2'h2;
  localparam logic [1:0] PI_HOUR = 2'h3;
  localparam logic [2:0] COF_OSC = 3'h0;
  localparam logic [2:0] COF_1HZ = 3'h6;
  localparam logic [2:0] COF_STATIC = 3'h7;
  localparam logic [1:0] STAMP_OFF = 2'h0;
  localparam logic [1:0] STAMP_IRQ_B = 2'h1;
  localparam logic [1:0] STAMP_CLK = 2'h2;
  localparam logic [1:0] STAMP_INPUT = 2'h3;
  localparam logic [1:0] IRQ_A_CLK = 2'h0;
  localparam logic [1:0] IRQ_A_BATT = 2'h1;
  localparam logic [1:0] IRQ_A_INT = 2'h2;
  localparam logic [1:0] IRQ_A_HIZ = 2'h3;
  // oscillator divider: 15 bits give 1 Hz at the top bit
  localparam int DIV_W = 15;
  localparam logic [14:0] DIV_LAST = 15'h7FFF;
  // 256 Hz comes every 128 oscillator edges
  localparam logic [6:0] T256_LAST = 7'h7F;
  localparam logic [1:0] HUND_DIV_LONG = 2'h3;
  localparam logic [1:0] HUND_DIV_SHORT = 2'h2;
  localparam logic [4:0] HUND_LONG_CNT = 5'h0E;
  localparam logic [4:0] HUND_CYCLE_LAST = 5'h18;
  localparam logic [5:0] SIXTY_LAST = 6'h3B;
  typedef struct packed {
    logic hundredths_enable;
    logic [1:0] periodic_interrupt_select;
    logic counting_mode_select;
    logic halt_source_select;
    logic [2:0] clock_out_freq_select;
  } func_ctrl_s;
endpackage

// file: rtc_function_control.sv
// rtc_function_control: function register, 100 Hz tick, periodic interrupt,
// halt control, clock-output divider and pin muxing.
// assumes osc_in is the 32.768 kHz level, synchronous to clk_in; write port
// comes from the serial bus logic; pin-control bits come from the pin register.
// How it works
// R1: battery indication mode: irq-a floats on main supply, pulls low on battery.
// R2: hundredths enable selects one-second or hundredth-second counting resolution.
// R3: 100 Hz tick from 256 Hz: divide by 3 fourteen times, then 2 eleven.
// R4: periodic select: none, per second, per minute, per hour.
// R5: periodic timers held reset while disabled; first pulse within last second.
// R6: periodic timers keep running while time counting is halted.
// R7: each periodic trigger sets the flag; pulses continue regardless of flag.
// R8: periodic period independent of offset calibration.
// R9: counting mode selects calendar counting or stop-watch up to 999999 hours.
// R10: halt source selects halt bit only, or halt bit or stamp pin.
// R11: host configures stamp pin as input before setting its polarity.
// R12: pin halting: halt bit wins, else pin active level halts counting.
// R13: clock select: 32768 Hz halving through 1024 Hz, then 1 Hz.
// R14: code 111: clock and stamp pins static low, irq-a floats.
// R15: clock invert applies to every code except 111.
// R16: clock pin push-pull, enabled after reset; disable bit forces it low.
// R17: same selected clock can go to stamp pin and irq-a pin.
// R18: all divided clocks have 50:50 duty; 32768 Hz follows the oscillator.
// R19: irq-a mode: clock, battery indication, interrupt, high impedance.
// R20: clock outputs come from a binary divider stepped by oscillator edges; code 0 drives osc_in straight out, not a divider bit.
`timescale 1ns/1ps
module rtc_function_control (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic osc_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic halt_bit_in,
  input wire logic stamp_pin_polarity_in,
  input wire logic [1:0] stamp_pin_mode_in,
  input wire logic [1:0] irq_a_pin_mode_in,
  input wire logic clock_pin_disable_in,
  input wire logic clock_out_invert_in,
  input wire logic battery_supply_in,
  input wire logic irq_a_data_n_in,
  input wire logic irq_b_data_n_in,
  input wire logic periodic_flag_clear_in,
  input wire logic stamp_pin_in,
  output logic [7:0] reg_rdata_out,
  output logic hundredths_enable_out,
  output logic counting_mode_out,
  output logic hundredths_tick_out,
  output logic second_tick_out,
  output logic count_halt_out,
  output logic periodic_pulse_out,
  output logic periodic_flag_out,
  output logic clk_pin_out,
  output logic stamp_pin_out,
  output logic stamp_pin_oe_out,
  output logic irq_a_pin_out,
  output logic irq_a_pin_oe_out
);
  rtc_fc_pkg::func_ctrl_s fc_r;
  logic [7:0] rdata_r;
  logic osc_r;
  logic [14:0] div_r;
  logic [6:0] t256_r;
  logic [1:0] hdiv_r;
  logic [4:0] hphase_r;
  logic [5:0] sec_cnt_r;
  logic [5:0] min_cnt_r;
  logic hund_tick_r, sec_tick_r, halt_r, pulse_r, flag_r;
  logic clk_pin_r, stamp_r, stamp_oe_r, irq_a_oe_r, irq_a_r;
  logic hund_en_r, mode_r;

  wire fc_wr = reg_wr_in && (reg_addr_in == rtc_fc_pkg::FUNC_CTRL_ADDR);
  wire osc_edge = osc_in && !osc_r;
  wire t256 = osc_edge && (t256_r == rtc_fc_pkg::T256_LAST);
  wire sec_wrap = osc_edge && (div_r == rtc_fc_pkg::DIV_LAST);
  wire [1:0] pi_sel = fc_r.periodic_interrupt_select;
  wire [2:0] cof = fc_r.clock_out_freq_select;
  wire cof_static = (cof == rtc_fc_pkg::COF_STATIC);

  // 100 Hz: 14 x 3 + 11 x 2 = 64 ticks of 256 Hz per 25 hundredths
  wire [1:0] hlimit = (hphase_r < rtc_fc_pkg::HUND_LONG_CNT) ?
                      rtc_fc_pkg::HUND_DIV_LONG : rtc_fc_pkg::HUND_DIV_SHORT; // [R3]
  wire hund_nxt = t256 && (hdiv_r == hlimit - 2'h1); // [R3]
  wire [1:0] hdiv_nxt = hund_nxt ? 2'h0 : (t256 ? hdiv_r + 2'h1 : hdiv_r);
  wire [4:0] hphase_nxt = !hund_nxt ? hphase_r :
                          (hphase_r == rtc_fc_pkg::HUND_CYCLE_LAST) ? 5'h00 : hphase_r + 5'h01;

  // periodic timers run off the raw divider, never off halt or calibration
  wire pi_on = (pi_sel != rtc_fc_pkg::PI_NONE); // [R5]
  wire sec_last = (sec_cnt_r == rtc_fc_pkg::SIXTY_LAST);
  wire min_last = (min_cnt_r == rtc_fc_pkg::SIXTY_LAST);
  wire min_wrap = sec_wrap && sec_last;
  wire hour_wrap = min_wrap && min_last;
  wire [5:0] sec_cnt_nxt = !pi_on ? 6'h00 : !sec_wrap ? sec_cnt_r :
                           sec_last ? 6'h00 : sec_cnt_r + 6'h01; // [R5] [R6]
  wire [5:0] min_cnt_nxt = !pi_on ? 6'h00 : !min_wrap ? min_cnt_r :
                           min_last ? 6'h00 : min_cnt_r + 6'h01; // [R5] [R6]
  wire pulse_nxt = (pi_sel == rtc_fc_pkg::PI_SEC) ? sec_wrap :
                   (pi_sel == rtc_fc_pkg::PI_MIN) ? min_wrap :
                   (pi_sel == rtc_fc_pkg::PI_HOUR) ? hour_wrap : 1'b0; // [R4] [R8]
  // set wins over a clear in the same cycle; flag never gates the pulse
  wire flag_nxt = pulse_nxt || (flag_r && !periodic_flag_clear_in); // [R7]

  // pin halt only counts once the stamp pin is an input
  wire pin_active = (stamp_pin_mode_in == rtc_fc_pkg::STAMP_INPUT) &&
                    (stamp_pin_in != stamp_pin_polarity_in); // [R11] [R12]
  wire halt_nxt = halt_bit_in || (fc_r.halt_source_select && pin_active); // [R10] [R12]

  // divided clocks are counter bits, so their duty is exact
  wire sel_clk = (cof == rtc_fc_pkg::COF_OSC) ? osc_in :
                 (cof == rtc_fc_pkg::COF_1HZ) ? div_r[rtc_fc_pkg::DIV_W - 1] :
                 cof_static ? 1'b0 : div_r[cof - 3'h1]; // [R13] [R18] [R20]
  wire clk_sig = cof_static ? 1'b0 : (sel_clk ^ clock_out_invert_in); // [R14] [R15]
  wire clk_pin_nxt = !clock_pin_disable_in && clk_sig; // [R16]

  wire stamp_drive = !battery_supply_in &&
                     ((stamp_pin_mode_in == rtc_fc_pkg::STAMP_IRQ_B) ||
                      (stamp_pin_mode_in == rtc_fc_pkg::STAMP_CLK));
  wire stamp_nxt = (stamp_pin_mode_in == rtc_fc_pkg::STAMP_CLK) ? clk_sig : irq_b_data_n_in; // [R17]
  // irq-a is open drain: enable high means pulling low
  wire irq_a_clk_oe = !battery_supply_in && !cof_static && !clk_sig; // [R14] [R17]
  wire irq_a_oe_nxt = (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_CLK) ? irq_a_clk_oe :
                      (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_BATT) ? battery_supply_in :
                      (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_INT) ? !irq_a_data_n_in :
                      1'b0; // [R1] [R19]

  wire [7:0] rdata_nxt = (reg_addr_in == rtc_fc_pkg::FUNC_CTRL_ADDR) ? fc_r : 8'h00;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fc_r <= rtc_fc_pkg::FUNC_CTRL_RESET;
      rdata_r <= 8'h00;
    end else begin
      if (fc_wr) begin
        fc_r <= reg_wdata_in;
      end
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_r <= 1'b0;
      div_r <= 15'h0000;
      t256_r <= 7'h00;
      hdiv_r <= 2'h0;
      hphase_r <= 5'h00;
      hund_tick_r <= 1'b0;
      sec_tick_r <= 1'b0;
    end else begin
      osc_r <= osc_in;
      if (osc_edge) begin
        div_r <= div_r + 15'h0001; // [R20]
        t256_r <= t256_r + 7'h01;
      end
      hdiv_r <= hdiv_nxt;
      hphase_r <= hphase_nxt;
      hund_tick_r <= hund_nxt && fc_r.hundredths_enable; // [R2]
      sec_tick_r <= sec_wrap;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sec_cnt_r <= 6'h00;
      min_cnt_r <= 6'h00;
      pulse_r <= 1'b0;
      flag_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;
      min_cnt_r <= min_cnt_nxt;
      pulse_r <= pulse_nxt;
      flag_r <= flag_nxt;
      halt_r <= halt_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_pin_r <= 1'b0;
      stamp_r <= 1'b0;
      stamp_oe_r <= 1'b0;
      irq_a_oe_r <= 1'b0;
      irq_a_r <= 1'b0;
      hund_en_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      clk_pin_r <= clk_pin_nxt;
      stamp_r <= stamp_nxt;
      stamp_oe_r <= stamp_drive;
      irq_a_oe_r <= irq_a_oe_nxt;
      irq_a_r <= 1'b0;
      hund_en_r <= fc_r.hundredths_enable; // [R2]
      mode_r <= fc_r.counting_mode_select; // [R9]
    end
  end

  // the calendar or stop-watch counters read mode_r and extend hours in mode 1
  assign reg_rdata_out = rdata_r;
  assign hundredths_enable_out = hund_en_r;
  assign counting_mode_out = mode_r;
  assign hundredths_tick_out = hund_tick_r;
  assign second_tick_out = sec_tick_r;
  assign count_halt_out = halt_r;
  assign periodic_pulse_out = pulse_r;
  assign periodic_flag_out = flag_r;
  assign clk_pin_out = clk_pin_r;
  assign stamp_pin_out = stamp_r;
  assign stamp_pin_oe_out = stamp_oe_r;
  assign irq_a_pin_out = irq_a_r;
  assign irq_a_pin_oe_out = irq_a_oe_r;

  // helper: 256 Hz ticks seen since the last 100 Hz tick
  logic [2:0] gap_r;
  logic gap_valid_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_r <= 3'h0;
      gap_valid_r <= 1'b0;
    end else if (hund_nxt) begin
      gap_r <= 3'h0;
      gap_valid_r <= 1'b1;
    end else if (t256) begin
      gap_r <= gap_r + 3'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_hund_gap: assert property (hund_nxt && gap_valid_r |-> (gap_r == 3'h1 || gap_r == 3'h2)) // [R3]
    else $error("100 Hz tick spacing wrong");
  a_flag_set: assert property (pulse_r |-> flag_r) // [R7]
    else $error("pulse without flag");
  a_flag_hold: assert property (flag_r && !periodic_flag_clear_in && !pulse_nxt |=> flag_r) // [R7]
    else $error("flag lost");
  a_timer_reset: assert property (!pi_on |=> sec_cnt_r == 6'h00 && min_cnt_r == 6'h00) // [R5]
    else $error("periodic timers not reset");
  a_pi_none: assert property ((pi_sel == rtc_fc_pkg::PI_NONE) [*2] |-> !pulse_r) // [R4]
    else $error("pulse while disabled");
  a_clk_disable: assert property (clock_pin_disable_in |=> !clk_pin_out) // [R16]
    else $error("clock pin not low when disabled");
  a_static_low: assert property (cof_static |=> !clk_pin_out && !(stamp_oe_r && stamp_r &&
                                 $past(stamp_pin_mode_in) == rtc_fc_pkg::STAMP_CLK)) // [R14]
    else $error("static code not low");
  a_batt_ind: assert property (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_BATT |=>
                               irq_a_pin_oe_out == $past(battery_supply_in)) // [R1]
    else $error("battery indication wrong");
  a_halt_bit: assert property (halt_bit_in |=> count_halt_out) // [R12]
    else $error("halt bit ignored");
  a_halt_src: assert property (!fc_r.halt_source_select && !halt_bit_in |=> !count_halt_out) // [R10]
    else $error("pin halted without source select");
  a_1hz_duty: assert property (cof == rtc_fc_pkg::COF_1HZ && !clock_pin_disable_in |=>
                               clk_pin_out == ($past(div_r[14]) ^ $past(clock_out_invert_in))) // [R13]
    else $error("1 Hz output wrong");

  c_pulse: cover property (pulse_r && flag_r);
  c_hund: cover property (hund_tick_r);
  c_halt_pin: cover property (!halt_bit_in && pin_active && fc_r.halt_source_select ##1 count_halt_out);
  c_batt: cover property (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_BATT && battery_supply_in ##1 irq_a_pin_oe_out);
  c_min: cover property (pi_sel == rtc_fc_pkg::PI_MIN && pulse_nxt);

  // helper: second wraps since the periodic timers left reset, saturating
  // so that the first pulse after enable can be told from later ones
  logic [6:0] wraps_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wraps_r <= 7'h00;
    end else if (!pi_on) begin
      wraps_r <= 7'h00;
    end else if (sec_wrap && wraps_r != 7'h7F) begin
      wraps_r <= wraps_r + 7'h01;
    end
  end

  // divider and tick chain
  a_div_step: assert property (osc_edge |=> div_r == $past(div_r) + 15'h0001) // [R20]
    else $error("divider missed an oscillator edge");
  a_div_hold: assert property (!osc_edge |=> $stable(div_r)) // [R20]
    else $error("divider moved without an edge");
  a_hund_gate: assert property (hund_tick_r |-> $past(fc_r.hundredths_enable)) // [R2]
    else $error("hundredths tick while disabled");
  a_hund_long: assert property (hund_nxt && hphase_r < rtc_fc_pkg::HUND_LONG_CNT |-> // [R3]
                                hdiv_r == rtc_fc_pkg::HUND_DIV_LONG - 2'h1)
    else $error("long hundredth period too short");
  a_hund_short: assert property (hund_nxt && hphase_r >= rtc_fc_pkg::HUND_LONG_CNT |-> // [R3]
                                 hdiv_r == rtc_fc_pkg::HUND_DIV_SHORT - 2'h1)
    else $error("short hundredth period wrong");
  a_mode_copy: assert property (1'b1 |=> counting_mode_out == $past(fc_r.counting_mode_select)) // [R9]
    else $error("counting mode not exported");

  // clock output selection; code 0 is checked against the oscillator, codes 1 to 5 against the raw divider
  a_osc_clk: assert property (cof == rtc_fc_pkg::COF_OSC && !clock_pin_disable_in |=> // [R13] [R18]
                              clk_pin_out == ($past(osc_in) ^ $past(clock_out_invert_in)))
    else $error("oscillator clock output wrong");
  a_div_clk: assert property (cof >= 3'h1 && cof <= 3'h5 && !clock_pin_disable_in |=> // [R13] [R18] [R20]
                              clk_pin_out == ($past(div_r[cof - 3'h1]) ^ $past(clock_out_invert_in)))
    else $error("divided clock output wrong");
  a_stamp_clk: assert property (stamp_pin_mode_in == rtc_fc_pkg::STAMP_CLK && !battery_supply_in && // [R17]
                                !clock_pin_disable_in |=> stamp_pin_oe_out && stamp_pin_out == clk_pin_out)
    else $error("stamp pin clock differs");
  a_stamp_batt: assert property (battery_supply_in |=> !stamp_pin_oe_out) // [R17]
    else $error("stamp pin driven on battery");
  a_irq_a_clk: assert property (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_CLK && !battery_supply_in && // [R17]
                                !cof_static && !clock_pin_disable_in |=> irq_a_pin_oe_out == !clk_pin_out)
    else $error("irq-a clock differs");
  a_static_irq: assert property (cof_static && irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_CLK |=> // [R14]
                                 !irq_a_pin_oe_out)
    else $error("irq-a pulled with static code");
  a_irq_a_hiz: assert property (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_HIZ |=> !irq_a_pin_oe_out) // [R19]
    else $error("irq-a pulled in high impedance mode");
  a_irq_a_int: assert property (irq_a_pin_mode_in == rtc_fc_pkg::IRQ_A_INT |=> // [R19]
                                irq_a_pin_oe_out == !$past(irq_a_data_n_in))
    else $error("irq-a interrupt data wrong");

  // periodic interrupt
  a_sec_pulse: assert property (pi_sel == rtc_fc_pkg::PI_SEC && sec_wrap |=> periodic_pulse_out) // [R4] [R6]
    else $error("second pulse missing");
  a_min_skip: assert property (pi_sel == rtc_fc_pkg::PI_MIN && sec_wrap && !sec_last |=> // [R4]
                               !periodic_pulse_out)
    else $error("minute pulse too early");
  a_pulse_once: assert property (periodic_pulse_out |=> !periodic_pulse_out) // [R4]
    else $error("periodic pulse longer than a cycle");
  a_flag_clear: assert property (periodic_flag_clear_in && !pulse_nxt |=> !periodic_flag_out) // [R7]
    else $error("flag not cleared");
  a_first_min: assert property (pi_sel == rtc_fc_pkg::PI_MIN && pulse_nxt |-> wraps_r >= 7'h3B) // [R5]
    else $error("first minute pulse too early");
  a_first_late: assert property (pi_sel == rtc_fc_pkg::PI_MIN && sec_wrap && wraps_r == 7'h3B |-> // [R5]
                                 pulse_nxt)
    else $error("first minute pulse late");

  // pin halting
  a_halt_run: assert property (!halt_bit_in && stamp_pin_mode_in == rtc_fc_pkg::STAMP_INPUT && // [R12]
                               stamp_pin_in == stamp_pin_polarity_in |=> !count_halt_out)
    else $error("halted with pin inactive");
  a_halt_pin: assert property (fc_r.halt_source_select && stamp_pin_mode_in == rtc_fc_pkg::STAMP_INPUT && // [R10]
                               stamp_pin_in != stamp_pin_polarity_in |=> count_halt_out)
    else $error("active pin did not halt");
endmodule

// file: osc_model.sv
// osc_model: far-side stand-in that makes the oscillator level and resolves the irq-a wire.
// assumes the bench clock; the oscillator level changes only on falling clock edges.
`timescale 1ns/1ps
module osc_model (
  input wire logic clk_in,
  input wire logic irq_a_oe_in,
  output logic osc_out,
  output wire logic irq_a_level_out
);
  // one level per system cycle, so one second costs only 65536 cycles
  initial begin
    osc_out = 1'b0;
    forever @(negedge clk_in) osc_out <= ~osc_out;
  end
  // open drain with a board pull-up
  assign irq_a_level_out = irq_a_oe_in ? 1'b0 : 1'b1;
endmodule

// file: rtc_function_control_tb.sv
// rtc_function_control_tb: register, pin, halt, clock-out, hundredths and periodic checks.
// assumes osc_model toggles the oscillator every cycle; inputs change at falling edges.
`timescale 1ns/1ps
module rtc_function_control_tb;
  logic clk_in, resetn_in, osc_in, reg_wr_in, halt_bit_in, stamp_pin_polarity_in, clock_pin_disable_in;
  logic clock_out_invert_in, battery_supply_in, irq_a_data_n_in, irq_b_data_n_in, periodic_flag_clear_in;
  logic stamp_pin_in, hundredths_enable_out, counting_mode_out, hundredths_tick_out, second_tick_out;
  logic count_halt_out, periodic_pulse_out, periodic_flag_out, clk_pin_out, stamp_pin_out, stamp_pin_oe_out;
  logic irq_a_pin_out, irq_a_pin_oe_out, irq_a_level;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [1:0] stamp_pin_mode_in, irq_a_pin_mode_in;
  int miscompares, n_tests;
  rtc_fc_pkg::func_ctrl_s fc;
  logic [4:0] hrow [7] = '{5'h02, 5'h0B, 5'h08, 5'h0D, 5'h0E, 5'h1F, 5'h11};
  logic [9:0] prow [6] = '{10'h14A, 10'h1EC, 10'h22F, 10'h332, 10'h072, 10'h2E0};
  rtc_function_control u_rtc_function_control (.clk_in, .resetn_in, .osc_in, .reg_wr_in, .reg_addr_in,
    .reg_wdata_in, .halt_bit_in, .stamp_pin_polarity_in, .stamp_pin_mode_in, .irq_a_pin_mode_in,
    .clock_pin_disable_in, .clock_out_invert_in, .battery_supply_in, .irq_a_data_n_in, .irq_b_data_n_in,
    .periodic_flag_clear_in, .stamp_pin_in, .reg_rdata_out, .hundredths_enable_out, .counting_mode_out,
    .hundredths_tick_out, .second_tick_out, .count_halt_out, .periodic_pulse_out, .periodic_flag_out,
    .clk_pin_out, .stamp_pin_out, .stamp_pin_oe_out, .irq_a_pin_out, .irq_a_pin_oe_out);
  osc_model u_osc_model (.clk_in(clk_in), .irq_a_oe_in(irq_a_pin_oe_out), .osc_out(osc_in),
    .irq_a_level_out(irq_a_level));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic timeout();
    miscompares++;
    $display("unexpected wait: expected event seen none");
    final_report();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // released a full cycle before returning so back-to-back writes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    cyc(1);
    reg_wr_in = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    cyc(2);
    chk("rdata", exp, reg_rdata_out);
  endtask
  task automatic wait_pin(input logic lvl, output int n);
    for (n = 0; n < 300 && clk_pin_out === lvl; n++) cyc(1);
    if (n == 300) timeout();
  endtask
  task automatic meas(input int code);
    int hi, lo;
    fc.clock_out_freq_select = code[2:0];
    wr(8'h28, fc);
    wait_pin(1'b1, hi);
    wait_pin(1'b0, lo);
    wait_pin(1'b1, hi);
    wait_pin(1'b0, lo);
    chk("clk high", 16'h0001 << code, hi[15:0]);
    chk("clk low", 16'h0001 << code, lo[15:0]);
  endtask
  task automatic tick_gap(output int g);
    for (g = 1; g <= 1000; g++) begin
      cyc(1);
      if (hundredths_tick_out === 1'b1) return;
    end
    timeout();
  endtask
  initial begin
    int g, tot, nl;
    {reg_wr_in, halt_bit_in, stamp_pin_polarity_in, clock_pin_disable_in, clock_out_invert_in} = 5'h00;
    {battery_supply_in, periodic_flag_clear_in, stamp_pin_in} = 3'h0;
    {irq_a_data_n_in, irq_b_data_n_in} = 2'h3;
    {reg_addr_in, reg_wdata_in, stamp_pin_mode_in, irq_a_pin_mode_in} = 20'h00000;
    miscompares = 0;
    n_tests = 0;
    fc = '0;
    resetn_in = 1'b0;
    cyc(5);
    resetn_in = 1'b1;
    rd(8'h28, 8'h00);
    wr(8'h29, 8'hFF);
    rd(8'h28, 8'h00);
    rd(8'h29, 8'h00);
    wr(8'h28, 8'h9B);
    rd(8'h28, 8'h9B);
    chk("mode", 1, {hundredths_enable_out, counting_mode_out} == 2'h3);
    fc.periodic_interrupt_select = rtc_fc_pkg::PI_SEC;
    wr(8'h28, fc);
    chk("hund off", 0, hundredths_enable_out);
    $display("test registers done");
    // pin must be an input before its polarity means anything
    stamp_pin_mode_in = rtc_fc_pkg::STAMP_INPUT;
    cyc(1);
    foreach (hrow[i]) begin
      fc.halt_source_select = hrow[i][3];
      wr(8'h28, fc);
      {halt_bit_in, stamp_pin_polarity_in, stamp_pin_in} = {hrow[i][4], hrow[i][2:1]};
      cyc(3);
      chk("halt", hrow[i][0], count_halt_out);
    end
    halt_bit_in = 1'b0;
    $display("test halt done");
    for (int c = 0; c < 6; c++) meas(c);
    clock_out_invert_in = 1'b1;
    meas(2);
    clock_pin_disable_in = 1'b1;
    cyc(3);
    for (int i = 0; i < 8; i++) begin
      chk("clk disabled", 0, clk_pin_out);
      cyc(1);
    end
    clock_pin_disable_in = 1'b0;
    $display("test clock out done");
    fc.clock_out_freq_select = rtc_fc_pkg::COF_STATIC;
    wr(8'h28, fc);
    foreach (prow[i]) begin
      {irq_a_pin_mode_in, battery_supply_in, irq_a_data_n_in, irq_b_data_n_in, stamp_pin_mode_in} = prow[i][9:3];
      cyc(3);
      chk("irq_a oe", prow[i][2], irq_a_pin_oe_out);
      chk("irq_a wire", !prow[i][2], irq_a_level);
      chk("stamp", prow[i][1:0], {stamp_pin_oe_out, stamp_pin_oe_out & stamp_pin_out});
      chk("static", 0, {clk_pin_out, irq_a_pin_out});
    end
    battery_supply_in = 1'b0;
    $display("test pins done");
    fc.hundredths_enable = 1'b1;
    wr(8'h28, fc);
    tick_gap(g);
    tot = 0;
    nl = 0;
    for (int k = 0; k < 25; k++) begin
      tick_gap(g);
      tot += g;
      nl += (g == 768);
      chk("tick gap", 1, g == 512 || g == 768);
    end
    chk("long gaps", 14, nl[15:0]);
    chk("gap total", 16'h4000, tot[15:0]);
    $display("test hundredths done");
    halt_bit_in = 1'b1;
    chk("no early pulse", 0, periodic_flag_out);
    for (g = 0; g < 66000 && periodic_pulse_out !== 1'b1; g++) cyc(1);
    if (g == 66000) timeout();
    chk("pulse", 3'h7, {periodic_flag_out, second_tick_out, count_halt_out});
    cyc(1);
    chk("after pulse", 2'h1, {periodic_pulse_out, periodic_flag_out});
    periodic_flag_clear_in = 1'b1;
    cyc(1);
    periodic_flag_clear_in = 1'b0;
    cyc(1);
    chk("flag clear", 0, periodic_flag_out);
    $display("test periodic done");
    final_report();
  end
endmodule
